// >>> hw/vpd_core.sv
// Packet dispatch core: fetch packet buffer, execute packet
// gathering, two register files with cross paths and eight units.
// Assumes zero-wait data memory and a handshaked program memory.
`timescale 1ns/10ps
// What this block does
// - Fetches 256-bit packets of eight 32-bit instruction slots.
// - Low bit one chains next instruction; zero ends the packet.
// - Execute packet holds at most eight instructions, issued together.
// - Execute packets may run across a fetch packet boundary.
// - One execute packet issued per clock to its units.
// - Next fetch only after all packets of current one dispatched, or at once on a taken branch.
// - One to eight execute packets per fetch packet handled.
// - Two register files of 32 words, 64 registers in all.
// - All four units of a side read their file without stall.
// - One cross path per side; shared operand allowed in a packet.
// - Cross read of register written last cycle stalls one cycle.
// - Only data-address units touch memory, either file as data.
// - Byte, half, word and doubleword loads and stores in one go.
// - Non-aligned word and doubleword access at any byte address.
// - Linear or circular addressing with 5- or 15-bit offsets.
// - Every instruction but the long-offset form conditional on a dedicated condition register.
// - Multiplier: dual 16x16, quad 8x8, 16x32 and dot products.
// - Multiplier: bit count, rotate, field multiply, variable shift.
// - Arith units: 32, dual 16 and quad 8 bit forms each cycle.
// - Wide product: upper word to long destination, lower to normal.
module vpd_core
  import vpd_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  // Program fetch
  output logic                        fetch_req,
  output logic      [31:0]            fetch_addr,
  input  wire logic                   fetch_valid,
  input  wire logic [FP_BITS-1:0]     fetch_data,
  // Data memory, one port per side
  output logic      [1:0]             dmem_req,
  output logic      [1:0]             dmem_we,
  output logic      [1:0][1:0]        dmem_size,
  output logic      [1:0]             dmem_unaligned,
  output logic      [1:0][31:0]       dmem_addr,
  output logic      [1:0][63:0]       dmem_wdata,
  input  wire logic [1:0][63:0]       dmem_rdata,
  // Circular block size, two to the power of this plus one
  input  wire logic [4:0]             circ_log2,
  // Dispatch status
  output logic                        ep_issue,
  output logic      [SLOTS-1:0]       ep_units,
  output logic                        xpath_stall
);

  typedef struct packed {
    logic [1:0][NREGS-1:0][31:0] rf;
    logic [1:0][NREGS-1:0]       last_wr;
    logic [31:0]                 pc;
    vpd_fetch_e                  fs;
    logic [FP_BITS-1:0]          fbuf;
    logic [2:0]                  ptr;
    logic [SLOTS-1:0]            carry_vld;
    logic [SLOTS-1:0][31:0]      carry;
    logic                        stalled;
    logic                        fetch_req;
    logic [1:0]                  ld_pend;
    logic [1:0][4:0]             ld_dst;
    logic [1:0]                  ld_side;
    logic [1:0][1:0]             ld_size;
    logic [1:0]                  dmem_req;
    logic [1:0]                  dmem_we;
    logic [1:0][1:0]             dmem_size;
    logic [1:0]                  dmem_unaligned;
    logic [1:0][31:0]            dmem_addr;
    logic [1:0][63:0]            dmem_wdata;
    logic                        ep_issue;
    logic [SLOTS-1:0]            ep_units;
    logic                        xpath_stall;
  } vpd_state_s;

  localparam vpd_state_s ST_RESET = '{fs: FS_FETCH, pc: PC_RESET,
                                      fetch_req: 1'b1, default: '0};

  vpd_state_s st;
  vpd_state_s next_st;

  // Gathered execute packet, one entry per unit
  logic [SLOTS-1:0][31:0] g_inst;
  logic [SLOTS-1:0]       g_vld;
  logic                   done;
  logic [2:0]             end_idx;
  logic [3:0]             cnt;
  logic                   xstall;
  logic [SLOTS-1:0]       cond_ok;
  logic [SLOTS-1:0][31:0] u_src1;
  logic [SLOTS-1:0][31:0] u_src2;
  logic [SLOTS-1:0][63:0] u_sdata;
  logic [SLOTS-1:0][14:0] u_off;
  logic [SLOTS-1:0][31:0] u_lo;
  logic [SLOTS-1:0][31:0] u_hi;
  logic [SLOTS-1:0]       u_long;

  // Condition check against the dedicated registers
  function automatic logic cond_true(input logic [31:0] inst,
      input logic [1:0][NREGS-1:0][31:0] rf);
    logic [31:0] v;
    logic        any;
    any = 1'b1;
    v = '0;
    case (inst[F_CREG +: 3])
      CR_B0:   v = rf[1][0];
      CR_B1:   v = rf[1][1];
      CR_B2:   v = rf[1][2];
      CR_A1:   v = rf[0][1];
      CR_A2:   v = rf[0][2];
      default: any = 1'b0;
    endcase
    if (!any)
      return 1'b1;
    return inst[F_Z] ? (v == '0) : (v != '0);
  endfunction

  // Sign extension of a load by access size
  function automatic logic [63:0] ld_ext(input logic [63:0] d,
      input logic [1:0] sz);
    case (sz)
      SZ_B:    return 64'($signed(d[7:0]));
      SZ_H:    return 64'($signed(d[15:0]));
      SZ_W:    return 64'($signed(d[31:0]));
      default: return d;
    endcase
  endfunction

  // Execute packet gathering and operand read
  always_comb
  begin
    logic [31:0] slot;
    logic [31:0] inst;
    logic        s;
    logic        ds;
    logic [4:0]  r2;
    g_inst = st.carry;
    g_vld = st.carry_vld;
    done = 1'b0;
    end_idx = '0;
    cnt = 4'($countones(st.carry_vld));
    xstall = 1'b0;
    slot = '0;
    inst = '0;
    s = 1'b0;
    ds = 1'b0;
    r2 = '0;
    for (int i = 0; i < SLOTS; i++)
    begin
      slot = st.fbuf[SLOT_BITS*i +: SLOT_BITS];
      if (st.fs == FS_RUN && 3'(i) >= st.ptr && !done)
      begin
        g_inst[slot[F_UNIT +: 3]] = slot;
        g_vld[slot[F_UNIT +: 3]] = 1'b1;
        cnt = cnt + 4'h1;
        // Chain bit clear, or a full packet, closes it
        if (!slot[F_CHAIN] || cnt == 4'h8)
        begin
          done = 1'b1;
          end_idx = 3'(i);
        end
      end
    end
    for (int u = 0; u < SLOTS; u++)
    begin
      inst = g_inst[u];
      s = (u >= 4);
      ds = s ^ inst[F_DSIDE];
      r2 = inst[F_SRC2 +: 5];
      // Same-side reads are all served at once
      u_src1[u] = st.rf[s][inst[F_SRC1 +: 5]];
      u_src2[u] = inst[F_CROSS] ? st.rf[!s][r2] : st.rf[s][r2];
      u_sdata[u] = {st.rf[ds][inst[F_DST +: 5] | 5'h01],
                    st.rf[ds][inst[F_DST +: 5]]};
      u_off[u] = {10'h000, r2};
      cond_ok[u] = g_vld[u] && cond_true(inst, st.rf);
      if (u[1:0] == K_DA && inst[F_MODE + M_LONG])
      begin
        // Long form: fixed base, 15-bit offset, unconditional
        u_src1[u] = st.rf[s][LONG_BASE];
        u_off[u] = {inst[31:28], inst[F_CROSS], inst[22:13]};
        cond_ok[u] = g_vld[u];
      end
      else if (u[1:0] != K_MU && u[1:0] != K_DA && inst[F_MODE + M_IMM])
        u_src2[u] = 32'($signed(r2));
      // Cross read of a register written last cycle waits one cycle
      if (g_vld[u] && inst[F_CROSS] && st.last_wr[!s][r2]
          && !st.stalled)
        xstall = 1'b1;
    end
  end

  // Eight units, kind from the low bits of the index
  generate
    for (genvar gu = 0; gu < SLOTS; gu++)
    begin : g_unit
      vpd_exec_unit #(
        .KIND (2'(gu % 4))
      ) u_unit (
        .op        (g_inst[gu][F_OP +: 4]),
        .mode      (g_inst[gu][F_MODE +: 3]),
        .src1      (u_src1[gu]),
        .src2      (u_src2[gu]),
        .offset    (u_off[gu]),
        .circ_log2 (circ_log2),
        .res_lo    (u_lo[gu]),
        .res_hi    (u_hi[gu]),
        .res_long  (u_long[gu])
      );
    end
  endgenerate

  // Next state: fetch, issue, write-back
  always_comb
  begin
    logic        s;
    logic        ds;
    logic        br;
    logic [31:0] tgt;
    logic [4:0]  d;
    logic [63:0] ld;
    next_st = st;
    next_st.last_wr = '0;
    next_st.dmem_req = '0;
    next_st.ld_pend = '0;
    next_st.ep_issue = 1'b0;
    next_st.ep_units = '0;
    next_st.xpath_stall = 1'b0;
    s = 1'b0;
    ds = 1'b0;
    br = 1'b0;
    tgt = '0;
    d = '0;
    ld = '0;
    // Fetch answer fills the packet buffer
    if (st.fs == FS_FETCH && st.fetch_req && fetch_valid)
    begin
      next_st.fbuf = fetch_data;
      next_st.fs = FS_RUN;
      next_st.fetch_req = 1'b0;
    end
    if (st.fs == FS_RUN)
    begin
      if (done && xstall)
      begin
        next_st.stalled = 1'b1;
        next_st.xpath_stall = 1'b1;
      end
      else if (done)
      begin
        // Whole packet goes out in this one cycle
        next_st.stalled = 1'b0;
        next_st.ep_issue = 1'b1;
        next_st.ep_units = g_vld;
        next_st.carry = '0;
        next_st.carry_vld = '0;
        for (int u = 0; u < SLOTS; u++)
        begin
          s = (u >= 4);
          d = g_inst[u][F_DST +: 5];
          ds = s ^ g_inst[u][F_DSIDE];
          if (cond_ok[u])
          begin
            if (u[1:0] == K_DA)
            begin
              // Only the address units reach data memory
              next_st.dmem_req[s] = 1'b1;
              next_st.dmem_we[s] = g_inst[u][F_OP + DA_STORE];
              next_st.dmem_size[s] = g_inst[u][F_OP +: 2];
              next_st.dmem_unaligned[s] =
                g_inst[u][F_OP + DA_UNAL];
              next_st.dmem_addr[s] = u_lo[u];
              next_st.dmem_wdata[s] = u_sdata[u];
              next_st.ld_pend[s] = !g_inst[u][F_OP + DA_STORE];
              next_st.ld_dst[s] = d;
              next_st.ld_side[s] = ds;
              next_st.ld_size[s] = g_inst[u][F_OP +: 2];
            end
            else if (u[1:0] == K_SB && g_inst[u][F_OP +: 4] == OP_BR)
            begin
              br = 1'b1;
              tgt = u_lo[u];
            end
            else
            begin
              next_st.rf[s][d] = u_lo[u];
              next_st.last_wr[s][d] = 1'b1;
              if (u_long[u])
              begin
                next_st.rf[s][d | 5'h01] = u_hi[u];
                next_st.last_wr[s][d | 5'h01] = 1'b1;
              end
            end
          end
        end
        // Branch refetches; last packet end fetches the next one
        if (br)
        begin
          next_st.pc = {tgt[31:5], 5'h00};
          next_st.ptr = tgt[4:2];
          next_st.fs = FS_FETCH;
          next_st.fetch_req = 1'b1;
        end
        else if (end_idx == 3'h7)
        begin
          next_st.pc = st.pc + FP_BYTES;
          next_st.ptr = '0;
          next_st.fs = FS_FETCH;
          next_st.fetch_req = 1'b1;
        end
        else
          next_st.ptr = end_idx + 3'h1;
      end
      else
      begin
        // Chain runs past slot seven: hold the part, fetch on
        next_st.carry = g_inst;
        next_st.carry_vld = g_vld;
        next_st.pc = st.pc + FP_BYTES;
        next_st.ptr = '0;
        next_st.fs = FS_FETCH;
        next_st.fetch_req = 1'b1;
      end
    end
    // Load data returns with the request and lands at the next edge
    for (int m = 0; m < 2; m++)
    begin
      if (st.ld_pend[m])
      begin
        ld = ld_ext(dmem_rdata[m], st.ld_size[m]);
        d = st.ld_dst[m];
        ds = st.ld_side[m];
        next_st.rf[ds][d] = ld[31:0];
        next_st.last_wr[ds][d] = 1'b1;
        if (st.ld_size[m] == SZ_DW)
        begin
          next_st.rf[ds][d | 5'h01] = ld[63:32];
          next_st.last_wr[ds][d | 5'h01] = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  // Outputs straight from the state flops
  assign fetch_req      = st.fetch_req;
  assign fetch_addr     = st.pc;
  assign dmem_req       = st.dmem_req;
  assign dmem_we        = st.dmem_we;
  assign dmem_size      = st.dmem_size;
  assign dmem_unaligned = st.dmem_unaligned;
  assign dmem_addr      = st.dmem_addr;
  assign dmem_wdata     = st.dmem_wdata;
  assign ep_issue       = st.ep_issue;
  assign ep_units       = st.ep_units;
  assign xpath_stall    = st.xpath_stall;

endmodule

// >>> hw/vpd_exec_unit.sv
// One functional unit: logic/arith, shift/branch, multiply or
// data-address kind, chosen by parameter. Purely combinational;
// operands arrive already read from the register files.
`timescale 1ns/10ps
module vpd_exec_unit
  import vpd_pkg::*;
#(
  parameter logic [1:0] KIND = K_LA
)
(
  // Decoded operation
  input  wire logic [3:0]  op,
  input  wire logic [2:0]  mode,
  input  wire logic [31:0] src1,
  input  wire logic [31:0] src2,
  input  wire logic [14:0] offset,
  input  wire logic [4:0]  circ_log2,
  // Results
  output logic      [31:0] res_lo,
  output logic      [31:0] res_hi,
  output logic             res_long
);

  // Lane-split add/sub: grp 0 single, 1 dual, 2 quad
  function automatic logic [31:0] lane_add(input logic [31:0] a,
      input logic [31:0] b, input logic sub, input logic [1:0] grp);
    logic       c;
    logic [8:0] s;
    logic [31:0] r;
    c = sub;
    r = '0;
    for (int i = 0; i < 4; i++)
    begin
      s = {1'b0, a[8*i +: 8]} + {1'b0, sub ? ~b[8*i +: 8] : b[8*i +: 8]}
          + {8'h00, c};
      r[8*i +: 8] = s[7:0];
      // Carry stops at every lane edge of the packed form
      c = (grp == 2'h2 || (grp == 2'h1 && i == 1)) ? sub : s[8];
    end
    return r;
  endfunction

  // Galois field byte multiply
  function automatic logic [7:0] gf_mul(input logic [7:0] a,
      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = '0;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ x;
      x = x[7] ? ((x << 1) ^ GF_POLY) : (x << 1);
    end
    return p;
  endfunction

  // Operation select by unit kind
  always_comb
  begin
    logic [3:0][15:0] pb;
    logic [1:0][31:0] ph;
    logic [63:0]      wide;
    logic [31:0]      off_s;
    logic [31:0]      mask;
    logic [31:0]      lin;
    logic [31:0]      neg;
    pb = '0;
    ph = '0;
    wide = '0;
    off_s = '0;
    mask = '0;
    lin = '0;
    neg = -src2;
    res_lo = '0;
    res_hi = '0;
    res_long = 1'b0;
    for (int i = 0; i < 4; i++)
      pb[i] = {8'h00, src1[8*i +: 8]} * {8'h00, src2[8*i +: 8]};
    for (int j = 0; j < 2; j++)
      ph[j] = 32'($signed(src1[16*j +: 16]) * $signed(src2[16*j +: 16]));
    case (KIND)
      K_MU:
      begin
        case (op)
          OP_MPY2:  {res_long, wide} = {1'b1, ph[1], ph[0]};
          OP_MPY4:  {res_long, wide} = {1'b1, pb};
          OP_MPYHW: {res_long, wide} =
                    {1'b1, 64'($signed(src1[15:0]) * $signed(src2))};
          OP_DOTP2: wide[31:0] = ph[0] + ph[1];
          OP_DOTPN: wide[31:0] = ph[1] - ph[0];
          OP_DOTPU: wide[31:0] = {16'h0000, pb[0]} + {16'h0000, pb[1]}
                               + {16'h0000, pb[2]} + {16'h0000, pb[3]};
          OP_BITC4:
            for (int i = 0; i < 4; i++)
              wide[8*i +: 8] = 8'($countones(src1[8*i +: 8]));
          OP_ROTL:  wide[31:0] = 32'({src1, src1} << src2[4:0] >> 32);
          OP_GMPY4:
            for (int i = 0; i < 4; i++)
              wide[8*i +: 8] = gf_mul(src1[8*i +: 8], src2[8*i +: 8]);
          // Negative amounts shift right, saturating at 31
          OP_SHVL:  wide[31:0] = src2[31]
                    ? (|neg[31:5] ? {32{src1[31]}}
                       : 32'($signed(src1) >>> neg[4:0]))
                    : (|src2[30:5] ? 32'h0000_0000 : src1 << src2[4:0]);
          default:  wide = '0;
        endcase
        // Upper half to the long destination
        {res_hi, res_lo} = wide;
      end
      K_DA:
      begin
        // Offset scaled by access size, linear or circular
        off_s = {17'h0_0000, offset} << op[1:0];
        lin = src1 + off_s;
        mask = 32'((33'h0_0000_0002 << circ_log2) - 33'h0_0000_0001);
        res_lo = mode[M_CIRC] ? ((src1 & ~mask) | (lin & mask)) : lin;
      end
      default:
      begin
        // Single, dual and quad lane forms every cycle
        if (op < OP_AND)
          res_lo = lane_add(src1, src2, op[0], op[2:1]);
        else
          case (op)
            OP_AND:  res_lo = src1 & src2;
            OP_OR:   res_lo = src1 | src2;
            OP_XOR:  res_lo = src1 ^ src2;
            OP_SHL:  res_lo = src1 << src2[4:0];
            OP_SHR:  res_lo = 32'($signed(src1) >>> src2[4:0]);
            OP_MVK:  res_lo = src2;
            OP_BR:   res_lo = src1;
            default: res_lo = '0;
          endcase
      end
    endcase
  end

endmodule

// >>> include/vpd_pkg.sv
// Shared constants for the packet dispatch core: fetch geometry,
// instruction field layout, unit kinds, operation codes and resets.
// Assumes a 32-byte aligned program memory and one clock domain.
package vpd_pkg;

  // Fetch packet geometry
  localparam int FP_BITS   = 256;
  localparam int SLOT_BITS = 32;
  localparam int SLOTS     = 8;
  localparam int NREGS     = 32;
  localparam logic [31:0] FP_BYTES = 32'h0000_0020;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  // Instruction field positions
  localparam int F_CHAIN = 0;
  localparam int F_UNIT  = 1;
  localparam int F_DSIDE = 4;
  localparam int F_MODE  = 5;
  localparam int F_DST   = 8;
  localparam int F_SRC1  = 13;
  localparam int F_SRC2  = 18;
  localparam int F_CROSS = 23;
  localparam int F_OP    = 24;
  localparam int F_Z     = 28;
  localparam int F_CREG  = 29;

  // Mode bits: immediate operand, circular and long-offset addressing
  localparam int M_IMM  = 0;
  localparam int M_CIRC = 0;
  localparam int M_LONG = 1;

  // Unit kinds, low two bits of the unit field; bit 2 is the side
  localparam logic [1:0] K_LA = 2'h0;
  localparam logic [1:0] K_SB = 2'h1;
  localparam logic [1:0] K_MU = 2'h2;
  localparam logic [1:0] K_DA = 2'h3;

  // Logic/arith and shift/branch operations
  localparam logic [3:0] OP_AND = 4'h6;
  localparam logic [3:0] OP_OR  = 4'h7;
  localparam logic [3:0] OP_XOR = 4'h8;
  localparam logic [3:0] OP_SHL = 4'h9;
  localparam logic [3:0] OP_SHR = 4'ha;
  localparam logic [3:0] OP_MVK = 4'hb;
  localparam logic [3:0] OP_BR  = 4'hc;

  // Multiplier operations
  localparam logic [3:0] OP_MPY2  = 4'h0;
  localparam logic [3:0] OP_MPY4  = 4'h1;
  localparam logic [3:0] OP_MPYHW = 4'h2;
  localparam logic [3:0] OP_DOTP2 = 4'h3;
  localparam logic [3:0] OP_DOTPN = 4'h4;
  localparam logic [3:0] OP_DOTPU = 4'h5;
  localparam logic [3:0] OP_BITC4 = 4'h6;
  localparam logic [3:0] OP_ROTL  = 4'h7;
  localparam logic [3:0] OP_GMPY4 = 4'h8;
  localparam logic [3:0] OP_SHVL  = 4'h9;

  // Data-address operation bits and access sizes
  localparam int DA_STORE = 3;
  localparam int DA_UNAL  = 2;
  localparam logic [1:0] SZ_B  = 2'h0;
  localparam logic [1:0] SZ_H  = 2'h1;
  localparam logic [1:0] SZ_W  = 2'h2;
  localparam logic [1:0] SZ_DW = 2'h3;

  // Condition register select codes
  localparam logic [2:0] CR_NONE = 3'h0;
  localparam logic [2:0] CR_B0   = 3'h1;
  localparam logic [2:0] CR_B1   = 3'h2;
  localparam logic [2:0] CR_B2   = 3'h3;
  localparam logic [2:0] CR_A1   = 3'h4;
  localparam logic [2:0] CR_A2   = 3'h5;

  // Base register of the long-offset form, field polynomial
  localparam logic [4:0] LONG_BASE = 5'h0f;
  localparam logic [7:0] GF_POLY   = 8'h1d;

  typedef enum logic {FS_FETCH, FS_RUN} vpd_fetch_e;

endpackage

// >>> testbench/vpd_core_assertions.sv
// Port checker for the dispatch core: fetch handshake and issue.
// Bound to vpd_core; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module vpd_core_assertions
  import vpd_pkg::*;
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst_b,
  // Fetch and dispatch
  input wire logic             fetch_req,
  input wire logic [31:0]      fetch_addr,
  input wire logic             fetch_valid,
  input wire logic             ep_issue,
  input wire logic [SLOTS-1:0] ep_units,
  input wire logic             xpath_stall
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Steps of the fetch handshake and of a stall
  sequence s_wait;
    fetch_req && !fetch_valid;
  endsequence
  sequence s_taken;
    fetch_req && fetch_valid;
  endsequence
  sequence s_stall_go;
    xpath_stall ##1 (ep_issue && !xpath_stall);
  endsequence

  AST_FETCH_HOLD: assert property (
    s_wait |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request not held");
  AST_FETCH_DROP: assert property (
    s_taken |=> !fetch_req) else $error("fetch request not dropped");
  AST_FETCH_ALIGN: assert property (
    fetch_req |-> fetch_addr[4:0] == 5'h00)
    else $error("fetch address not packet aligned");
  AST_RESET_FETCH: assert property (
    $rose(rst_b) |-> fetch_req && fetch_addr == 32'h0000_0000)
    else $error("first fetch not at address zero");
  AST_IDLE_UNITS: assert property (
    !ep_issue |-> ep_units == '0) else $error("units without issue");
  AST_ISSUE_UNITS: assert property (
    ep_issue |-> ep_units != '0) else $error("issue with no units");
  AST_STALL_GO: assert property (
    xpath_stall |-> s_stall_go) else $error("stall not one cycle");
  AST_STALL_HOLD: assert property (
    xpath_stall |-> !ep_issue) else $error("issue during stall");
endmodule

bind vpd_core vpd_core_assertions vpd_core_assertions_inst (.clock,
  .rst_b, .fetch_req, .fetch_addr, .fetch_valid, .ep_issue, .ep_units,
  .xpath_stall);

// >>> testbench/vpd_core_test.sv
// Self-checking bench for the packet dispatch core.
// Inputs change at the falling edge; memory model answers fetches.
`timescale 1ns/10ps
module vpd_core_test
  import vpd_pkg::*;
;
  logic                clock = 1'b0;
  logic                rst_b = 1'b0;
  logic [4:0]          circ_log2 = 5'h03;
  logic                fetch_req, fetch_valid, ep_issue, xpath_stall;
  logic [31:0]         fetch_addr;
  logic [FP_BITS-1:0]  fetch_data;
  logic [1:0]          dmem_req, dmem_we, dmem_unaligned;
  logic [1:0][1:0]     dmem_size;
  logic [1:0][31:0]    dmem_addr;
  logic [1:0][63:0]    dmem_wdata, dmem_rdata;
  logic [7:0]          ep_units;
  logic                seen_stall = 1'b0;
  int                  mismatches = 0;
  int                  cmp_count = 0;

  // Free-running 200 MHz clock
  always #2.5 clock = ~clock;

  vpd_core vpd_core_inst (.clock, .rst_b, .fetch_req, .fetch_addr,
    .fetch_valid, .fetch_data, .dmem_req, .dmem_we, .dmem_size,
    .dmem_unaligned, .dmem_addr, .dmem_wdata, .dmem_rdata, .circ_log2,
    .ep_issue, .ep_units, .xpath_stall);
  vpd_mem_model vpd_mem_model_inst (.clock, .fetch_req, .fetch_addr,
    .fetch_valid, .fetch_data, .dmem_req, .dmem_addr, .dmem_rdata);

  // Instruction word from its fields, condition always true
  function automatic logic [31:0] enc(input logic c,
    input logic [2:0] u, m, input logic [4:0] d, s1, s2,
    input logic x, input logic [3:0] op);
    enc = {4'h0, op, x, s2, s1, d, m, 1'b0, u, c};
  endfunction

  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  // One program word into the memory model
  task put(input int a, input logic [31:0] w);
    vpd_mem_model_inst.prog[a] = w;
  endtask

  // Filler is a lone move into a scratch register
  task clear(input int l);
    for (int i = 0; i < 64; i++)
      put(i, enc(0, 0, 1, 31, 0, 0, 0, OP_MVK));
    vpd_mem_model_inst.lat = l;
  endtask

  task do_reset;
    @(negedge clock);
    rst_b = 1'b0;
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
  endtask

  // Next issue, noting any stall cycle before it; bounded
  task wait_issue(output logic [7:0] u);
    int n;
    n = 0;
    @(negedge clock);
    while (ep_issue !== 1'b1 && n < 60)
    begin
      if (xpath_stall === 1'b1)
        seen_stall = 1'b1;
      n++;
      @(negedge clock);
    end
    if (n >= 60)
    begin
      mismatches++;
      summarize;
    end
    u = ep_units;
  endtask

  // Next side-A store: address, size, variant and data
  task chk_store(input logic [31:0] a, input logic [1:0] sz,
    input logic un, input logic [63:0] wd);
    int n;
    n = 0;
    while ((dmem_req[0] !== 1'b1 || dmem_we[0] !== 1'b1) && n < 60)
    begin
      n++;
      @(negedge clock);
    end
    if (n >= 60)
    begin
      mismatches++;
      summarize;
    end
    chk("dmem_addr", 64'(a), 64'(dmem_addr[0]));
    chk("dmem_size", 64'(sz), 64'(dmem_size[0]));
    chk("dmem_unaligned", 64'(un), 64'(dmem_unaligned[0]));
    chk("dmem_wdata", wd, (sz == SZ_DW) ? dmem_wdata[0] :
      64'(dmem_wdata[0][31:0]));
    @(negedge clock);
  endtask

  // Eight lone packets, then one packet of all eight units
  task sc_rate;
    logic [7:0] u;
    clear(0);
    for (int i = 0; i < 8; i++)
    begin
      put(i, enc(0, i[2:0], 0, 31, 0, 0, 0, 4'h2));
      put(8 + i, enc(i < 7, i[2:0], 0, 31, 0, 0, 0, 4'h2));
    end
    do_reset;
    for (int i = 0; i < 8; i++)
    begin
      wait_issue(u);
      chk("ep_units", 64'(8'h01 << i), 64'(u));
      if (i < 7)
        chk("fetch_req", 64'h0, 64'(fetch_req));
    end
    wait_issue(u);
    chk("ep_units", 64'h00ff, 64'(u));
  endtask

  // Packet chained across the fetch boundary, slow memory
  task sc_cross;
    logic [7:0] u;
    clear(3);
    put(6, enc(1, 1, 1, 30, 0, 1, 0, OP_MVK));
    put(7, enc(1, 2, 0, 28, 0, 0, 0, 4'h2));
    put(8, enc(0, 5, 0, 31, 0, 0, 0, 4'h2));
    do_reset;
    repeat (7) wait_issue(u);
    chk("ep_units", 64'h0026, 64'(u));
  endtask

  // Moves, wide product, doubleword, unaligned and circular stores, load then store
  task sc_data;
    clear(1);
    put(0, enc(0, 0, 1, 1, 0, 4, 0, OP_MVK));
    put(1, enc(0, 1, 1, 2, 0, 20, 0, OP_MVK));
    put(2, enc(0, 0, 1, 3, 0, 3, 0, OP_MVK));
    put(3, enc(0, 2, 0, 4, 3, 1, 0, OP_MPYHW));
    put(4, enc(0, 3, 0, 4, 1, 2, 0, 4'hb));
    put(5, enc(0, 3, 0, 2, 3, 1, 0, 4'he));
    put(6, enc(0, 3, 0, 7, 0, 2, 0, 4'h2));
    put(7, enc(0, 3, 1, 1, 3, 5, 0, 4'ha));
    put(8, enc(0, 3, 0, 7, 0, 0, 0, 4'ha));
    do_reset;
    chk_store(32'h0000_0014, SZ_DW, 0, 64'h000c);
    chk_store(32'h0000_0007, SZ_W, 1, 64'hffff_fff4);
    chk_store(32'h0000_0007, SZ_W, 0, 64'h0004);
    chk_store(32'h0000_0000, SZ_W, 0, 64'h5a00_0002);
  endtask

  // Cross read right after a write, two units sharing it
  task sc_stall;
    logic [7:0] u;
    clear(0);
    put(0, enc(0, 4, 1, 5, 0, 7, 0, OP_MVK));
    put(1, enc(1, 0, 0, 6, 0, 5, 1, 4'h0));
    put(2, enc(0, 1, 0, 8, 0, 5, 1, 4'h0));
    // False condition on B1: this move must not land
    put(3, enc(0, 0, 1, 6, 0, 9, 0, OP_MVK) | 32'h4000_0000);
    put(4, enc(0, 3, 0, 6, 0, 0, 0, 4'ha));
    do_reset;
    wait_issue(u);
    seen_stall = 1'b0;
    wait_issue(u);
    chk("xpath_stall", 64'h1, 64'(seen_stall));
    chk("ep_units", 64'h0003, 64'(u));
    chk_store(32'h0000_0000, SZ_W, 0, 64'h0007);
  endtask

  // Main sequence
  initial
  begin
    sc_rate;
    sc_cross;
    sc_data;
    sc_stall;
    summarize;
  end
endmodule

// >>> testbench/vpd_mem_model.sv
// Program and data memory model facing the dispatch core.
// Fetch answers after lat cycles; data reads are zero wait.
`timescale 1ns/10ps
module vpd_mem_model
  import vpd_pkg::*;
(
  // Clock
  input  wire logic               clock,
  // Program side
  input  wire logic               fetch_req,
  input  wire logic [31:0]        fetch_addr,
  output logic                    fetch_valid,
  output logic      [FP_BITS-1:0] fetch_data,
  // Data side
  input  wire logic [1:0]         dmem_req,
  input  wire logic [1:0][31:0]   dmem_addr,
  output logic      [1:0][63:0]   dmem_rdata
);
  logic [31:0] prog [0:63];
  logic [31:0] dm   [0:15];
  logic        junk = 1'b0;
  int          lat = 0;
  int          cnt = 0;

  // Known data words
  initial
    for (int i = 0; i < 16; i++)
      dm[i] = 32'h5a00_0000 | 32'(i);

  // One-cycle answer, only to a standing request
  always @(posedge clock)
  begin
    junk <= ~junk;
    fetch_valid <= 1'b0;
    cnt <= (fetch_req && !fetch_valid) ? cnt + 1 : 0;
    if (fetch_req && !fetch_valid && cnt >= lat)
    begin
      fetch_valid <= 1'b1;
      cnt <= 0;
    end
  end

  // Lines toggle outside answers so stale values never look valid
  always @*
  begin
    for (int i = 0; i < SLOTS; i++)
      fetch_data[32*i +: 32] = fetch_valid ?
        prog[{fetch_addr[7:5], i[2:0]}] : {32{junk}};
    for (int s = 0; s < 2; s++)
      dmem_rdata[s] = dmem_req[s] ? {dm[dmem_addr[s][5:2] + 4'h1],
        dm[dmem_addr[s][5:2]]} : {64{junk}};
  end
endmodule
